// file: bench/fchp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "fchp_defines.svh"
module fchp_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`FCHP_ADDR_W-1:0] addr,
  input wire logic [1:0] data_host_oe,
  input wire logic [1:0] data_card_oe,
  input wire logic output_enable_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic task_file_select_n,
  input wire logic control_block_select_n,
  input wire logic ide_mode_select_n,
  input wire logic input_acknowledge_n,
  input wire logic ready_busy_n,
  input wire logic reset_pin
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire rd = !io_read_strobe_n || !output_enable_n;
  wire ide = !ide_mode_select_n;
  // the host is built with a strobe of 4 cycles, so it stands low for 5
  sequence wr_pulse;
    !io_write_strobe_n[*5] ##1 io_write_strobe_n;
  endsequence
  a_ack_on_read:
    assert property (!input_acknowledge_n |-> !ide && (!io_read_strobe_n
      || !$past(io_read_strobe_n) || !$past(io_read_strobe_n, 2))) else $error("stray ack");
  a_card_drive_read:
    assert property (|data_card_oe |-> rd || $past(rd) || $past(rd, 2) || $past(rd, 3))
      else $error("card drives outside read");
  a_no_lane_clash:
    assert property ((data_host_oe & data_card_oe) == 2'h0) else $error("lane clash");
  a_strobe_when_ready:
    assert property ($fell(io_read_strobe_n) || $fell(io_write_strobe_n)
      || $fell(output_enable_n) |-> $past(ready_busy_n)) else $error("access while busy");
  a_write_pulse:
    assert property ($fell(io_write_strobe_n) |-> wr_pulse) else $error("write pulse width");
  a_ide_addr_low:
    assert property (ide && !task_file_select_n |-> addr[`FCHP_ADDR_W-1:3] == '0)
      else $error("upper address set");
  a_ide_byte_lane:
    assert property (ide && (!control_block_select_n || (!task_file_select_n
      && addr[2:0] != 3'h0)) |-> !data_card_oe[1] && !data_host_oe[1]) else $error("high lane");
  a_busy_after_reset:
    assert property ($fell(reset_pin) |-> ##[1:3] !ready_busy_n) else $error("no reset busy");
endmodule
`default_nettype wire

// file: bench/flash_card_host_bus_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fchp_defines.svh"
module flash_card_host_bus_port_bench;
  import fchp_pkg::*;
  logic clk_in = 0, rst_in = 1, io_mode_in = 0, ide_mode_in = 0, card_reset_in = 1;
  logic master_in = 0, wr_ready_in = 1, busy_in = 0, req_valid_in = 0;
  fchp_op_t req_op_in = FCHP_OP_WRITE;
  logic [`FCHP_ADDR_W-1:0] req_addr_in = '0, wr_addr_out;
  logic [15:0] req_data_in = '0, w, rsp_data_out, wr_data_out;
  logic [15:0] rb[8];
  logic req_ready_out, rsp_valid_out, wr_valid_out, drive_master_out;
  logic ack_seen = 0;
  fchp_mode_t mode_out;
  int bad_count = 0, n_tests = 0, i;
  logic [31:0] exp_rd[$], exp_wr[$];
  fchp_bus_if bus ();
  fchp_host #(.STROBE_CYC(4)) fchp_host_inst (.clk_in, .rst_in, .ide_mode_in, .master_in,
    .card_reset_in, .req_valid_in, .req_ready_out, .req_op_in, .req_addr_in, .req_data_in,
    .rsp_valid_out, .rsp_data_out, .bus);
  fchp_card #(.INIT_CYC(10)) fchp_card_inst (.clk_in, .rst_in, .io_mode_in, .bus,
    .drive_master_out, .mode_out, .wr_valid_out, .wr_data_out, .wr_addr_out, .wr_ready_in,
    .busy_in);
  fchp_monitor fchp_monitor_inst (.clk_in, .rst_in, .addr(bus.addr),
    .data_host_oe(bus.data_host_oe), .data_card_oe(bus.data_card_oe),
    .output_enable_n(bus.output_enable_n), .io_read_strobe_n(bus.io_read_strobe_n),
    .io_write_strobe_n(bus.io_write_strobe_n), .task_file_select_n(bus.task_file_select_n),
    .control_block_select_n(bus.control_block_select_n),
    .ide_mode_select_n(bus.ide_mode_select_n), .input_acknowledge_n(bus.input_acknowledge_n),
    .ready_busy_n(bus.ready_busy_n), .reset_pin(bus.reset_pin));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic close_out();
    if (exp_rd.size() != 0 || exp_wr.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (e !== s) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // an empty queue forces a mismatch, so a spurious result is never lost
  task automatic cmp(ref logic [31:0] q[$], input logic [15:0] s, input string n);
    logic [31:0] e;
    e = q.size() ? q.pop_front() : {16'hffff, ~s};
    chk(n, e[15:0] & e[31:16], s & e[31:16]);
  endtask
  always @(posedge clk_in) begin
    if (bus.input_acknowledge_n === 1'b0) ack_seen = 1;
    if (rsp_valid_out === 1'b1) cmp(exp_rd, rsp_data_out, "read");
    if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1) cmp(exp_wr, wr_data_out, "write");
  end
  task automatic wait_ready();
    int k;
    k = 0;
    while (req_ready_out !== 1'b1) begin
      @(negedge clk_in);
      k++;
      if (k > 400) begin
        bad_count++;
        close_out();
      end
    end
  endtask
  // the gap outlasts the card's two-stage delayed write capture and any reply
  task automatic req(fchp_op_t op, int a, logic [15:0] d, logic [15:0] m);
    wait_ready();
    req_op_in = op;
    req_addr_in = a[`FCHP_ADDR_W-1:0];
    req_data_in = d;
    req_valid_in = 1;
    @(negedge clk_in);
    req_valid_in = 0;
    if (op inside {FCHP_OP_READ, FCHP_OP_MEMRD, FCHP_OP_CTLRD}) exp_rd.push_back({m, d});
    else if (m != 0) exp_wr.push_back({m, d});
    repeat (12) @(negedge clk_in);
  endtask
  initial begin
    void'($urandom(84612));
    repeat (8) @(negedge clk_in);
    rst_in = 0;
    repeat (3) @(negedge clk_in);
    chk("ready", 1, 16'(bus.ready_busy_n));
    card_reset_in = 0;
    repeat (3) @(negedge clk_in);
    chk("busy", 0, 16'(bus.ready_busy_n));
    wait_ready();
    $display("test reset done");
    ide_mode_in = 1;
    for (i = 0; i < 2; i++) begin
      master_in = i[0];
      repeat (3) @(negedge clk_in);
      chk("master", 16'(i[0]), 16'(drive_master_out));
    end
    chk("mode", 16'(FCHP_IDE), 16'(mode_out));
    for (i = 0; i < 8; i++) if (i != 1) begin
      rb[i] = 16'($urandom);
      req(FCHP_OP_WRITE, i, rb[i], i ? 16'h00ff : 16'hffff);
    end
    for (i = 0; i < 8; i++) if (i != 1) req(FCHP_OP_READ, i, rb[i], i ? 16'h00ff : 16'hffff);
    $display("test ide done");
    ide_mode_in = 0;
    req(FCHP_OP_WRITE, 2, ~rb[2], 16'h0);
    req(FCHP_OP_MEMRD, 2, rb[2], 16'h00ff);
    busy_in = 1;
    repeat (4) @(negedge clk_in);
    chk("busy", 0, 16'(bus.ready_busy_n));
    busy_in = 0;
    repeat (4) @(negedge clk_in);
    chk("ready", 1, 16'(bus.ready_busy_n));
    chk("ack", 0, 16'(ack_seen));
    $display("test memory done");
    io_mode_in = 1;
    w = 16'($urandom);
    req(FCHP_OP_WRITE, 0, w, 16'hffff);
    req(FCHP_OP_READ, 0, w, 16'hffff);
    chk("ack", 1, 16'(ack_seen));
    req(FCHP_OP_MEMRD, 2, rb[2], 16'h00ff);
    wr_ready_in = 0;
    for (i = 0; i < 12; i++) begin
      repeat (12) @(negedge clk_in);
      if (req_ready_out !== 1'b1) break;
      req(FCHP_OP_WRITE, 3, 16'($urandom), 16'h00ff);
    end
    chk("depth", 16'(`FCHP_FIFO_DEPTH), 16'(i));
    repeat (60) begin
      wr_ready_in = 1'($urandom);
      @(negedge clk_in);
    end
    wr_ready_in = 1;
    wait_ready();
    $display("test io done");
    // fifo held stalled here, so control writes wait at its output and are never popped
    wr_ready_in = 0;
    ide_mode_in = 1;
    req(FCHP_OP_CTLWR, 6, w, 16'h0);
    req(FCHP_OP_CTLRD, 6, w, 16'h00ff);
    $display("test control done");
    close_out();
  end
endmodule
`default_nettype wire

// file: hdl/fchp_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "fchp_defines.svh"
interface fchp_bus_if;
  logic [`FCHP_ADDR_W-1:0] addr;
  logic [`FCHP_DATA_W-1:0] data_host;
  logic [`FCHP_DATA_W-1:0] data_card;
  logic [1:0] data_host_oe;
  logic [1:0] data_card_oe;
  logic output_enable_n;
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic task_file_select_n;
  logic control_block_select_n;
  logic ide_mode_select_n;
  logic drive_role_select;
  logic input_acknowledge_n;
  logic ready_busy_n;
  logic reset_pin;
  wire [`FCHP_DATA_W-1:0] data = {
    data_host_oe[1] ? data_host[`FCHP_HI_LANE] : data_card[`FCHP_HI_LANE],
    data_host_oe[0] ? data_host[`FCHP_LO_LANE] : data_card[`FCHP_LO_LANE]};
  modport card (input addr, data, data_host_oe, output_enable_n, io_read_strobe_n,
    io_write_strobe_n, task_file_select_n, control_block_select_n, ide_mode_select_n,
    drive_role_select, reset_pin, output data_card, data_card_oe, input_acknowledge_n,
    ready_busy_n);
  modport host (output addr, data_host, data_host_oe, output_enable_n, io_read_strobe_n,
    io_write_strobe_n, task_file_select_n, control_block_select_n, ide_mode_select_n,
    drive_role_select, reset_pin, input data, data_card_oe, input_acknowledge_n,
    ready_busy_n);
endinterface
`default_nettype wire

// file: hdl/fchp_card.sv
`timescale 1ns/1ps
`default_nettype none
`include "fchp_defines.svh"
module fchp_card
  import fchp_pkg::*;
#(
  parameter int INIT_CYC = `FCHP_INIT_CYC,
  parameter int DEPTH = `FCHP_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic io_mode_in,
  fchp_bus_if.card bus,
  output logic drive_master_out,
  output fchp_mode_t mode_out,
  output logic wr_valid_out,
  output logic [`FCHP_DATA_W-1:0] wr_data_out,
  output logic [`FCHP_ADDR_W-1:0] wr_addr_out,
  input wire logic wr_ready_in,
  input wire logic busy_in
);
  logic [2:0] oe_s;
  logic [2:0] rd_s;
  logic [2:0] wr_s;
  logic por_seen_low;
  logic [$clog2(INIT_CYC+1)-1:0] init_cnt;
  logic init_busy;
  logic [`FCHP_BYTE_W-1:0] regs [`FCHP_REGS];
  logic [`FCHP_BYTE_W-1:0] ctl_reg;
  logic [`FCHP_DATA_W-1:0] rd_data;
  logic rd_drive;
  logic [1:0] rd_lanes;
  logic selected;
  logic wr_rise;
  logic fifo_ready;
  logic [`FCHP_DATA_W+`FCHP_ADDR_W-1:0] fifo_out;
  logic [2:0] idx;
  logic [2:0] widx;
  logic [`FCHP_BYTE_W-1:0] data_hi;
  logic [`FCHP_ADDR_W-1:0] cap_addr [2];
  logic [`FCHP_DATA_W-1:0] cap_data [2];
  logic [1:0] cap_oe [2];
  logic cap_tf_n [2];
  logic cap_cb_n [2];

  function automatic logic [2:0] tf_index(input logic [`FCHP_ADDR_W-1:0] a);
    return a[`FCHP_TF_ADDR_W-1:0];
  endfunction

  assign mode_out = !bus.ide_mode_select_n ? FCHP_IDE : (io_mode_in ? FCHP_IO : FCHP_MEM);
  assign drive_master_out = !bus.drive_role_select;
  assign selected = !bus.task_file_select_n || !bus.control_block_select_n;
  assign idx = tf_index(bus.addr);
  assign widx = tf_index(cap_addr[1]);

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_s <= 3'h7;
      rd_s <= 3'h7;
      wr_s <= 3'h7;
    end else begin
      oe_s <= {oe_s[1:0], bus.output_enable_n};
      rd_s <= {rd_s[1:0], bus.io_read_strobe_n};
      wr_s <= {wr_s[1:0], bus.io_write_strobe_n};
    end
  end
  assign wr_rise = !wr_s[2] && wr_s[1] && mode_out != FCHP_MEM;

  // selects and lanes ride two stages beside the write strobe, so the
  // trailing-edge capture still sees them after the host has let go
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cap_tf_n[0] <= 1'b1;
      cap_tf_n[1] <= 1'b1;
      cap_cb_n[0] <= 1'b1;
      cap_cb_n[1] <= 1'b1;
      cap_oe[0] <= 2'h0;
      cap_oe[1] <= 2'h0;
    end else begin
      cap_tf_n[0] <= bus.task_file_select_n;
      cap_tf_n[1] <= cap_tf_n[0];
      cap_cb_n[0] <= bus.control_block_select_n;
      cap_cb_n[1] <= cap_cb_n[0];
      cap_oe[0] <= bus.data_host_oe;
      cap_oe[1] <= cap_oe[0];
    end
  end

  // no reset on the data stages, the qualified write strobe gates their use
  always_ff @(posedge clk_in) begin
    cap_addr[0] <= bus.addr;
    cap_addr[1] <= cap_addr[0];
    cap_data[0] <= bus.data;
    cap_data[1] <= cap_data[0];
  end

  // reset pin seen low once after power-up, else ready stays high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      por_seen_low <= 1'b0;
    end else if (!bus.reset_pin) begin
      por_seen_low <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      init_cnt <= '0;
      init_busy <= 1'b0;
    end else if (bus.reset_pin) begin
      init_busy <= por_seen_low;
      init_cnt <= '0;
    end else if (init_busy || !por_seen_low) begin
      if (init_cnt == ($bits(init_cnt))'(INIT_CYC)) begin
        init_busy <= 1'b0;
      end else begin
        init_cnt <= init_cnt + 1'b1;
        init_busy <= 1'b1;
      end
    end
  end
  // host must stay off while busy, writes are dropped while init_busy, always in memory mode, and at the fifo when full
  assign bus.ready_busy_n = !(init_busy || busy_in || !fifo_ready);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < `FCHP_REGS; i++) begin
        regs[i] <= 8'h00;
      end
      ctl_reg <= 8'h00;
      data_hi <= 8'h00;
    end else if (wr_rise && !init_busy) begin
      if (!cap_tf_n[1]) begin
        regs[widx] <= cap_data[1][`FCHP_LO_LANE];
        if (widx == 3'h0 && cap_oe[1][1]) begin
          data_hi <= cap_data[1][`FCHP_HI_LANE];
        end
      end else if (!cap_cb_n[1]) begin
        ctl_reg <= cap_data[1][`FCHP_LO_LANE];
      end
    end
  end

  always_comb begin
    rd_drive = 1'b0;
    rd_lanes = 2'h0;
    // synced edge starts the drivers, a released strobe drops them at once
    unique case (mode_out)
      FCHP_MEM: begin
        rd_drive = !oe_s[1] && !bus.output_enable_n;
        rd_lanes = 2'h3;
      end
      FCHP_IO: begin
        rd_drive = (!rd_s[1] && !bus.io_read_strobe_n && selected)
          || (!oe_s[1] && !bus.output_enable_n);
        rd_lanes = 2'h3;
      end
      FCHP_IDE: begin
        rd_drive = !rd_s[1] && !bus.io_read_strobe_n && selected;
        rd_lanes = (idx == 3'h0 && !bus.task_file_select_n) ? 2'h3 : 2'h1;
      end
      default: begin
        rd_drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data <= 16'h0000;
    end else if (!bus.control_block_select_n) begin
      rd_data <= {8'h00, ctl_reg};
    end else if (idx == 3'h0) begin
      rd_data <= {data_hi, regs[0]};
    end else begin
      rd_data <= {8'h00, regs[idx]};
    end
  end
  assign bus.data_card = rd_data;
  assign bus.data_card_oe = rd_drive ? rd_lanes : 2'h0;
  assign bus.input_acknowledge_n = !(mode_out == FCHP_IO && selected && !rd_s[1]);

  fchp_fifo #(.WIDTH(`FCHP_DATA_W + `FCHP_ADDR_W), .DEPTH(DEPTH)) fchp_fifo_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(wr_rise && !init_busy && cap_oe[1] != 2'h0),
    .in_ready_out(fifo_ready),
    .in_data_in({cap_addr[1], cap_data[1]}),
    .out_valid_out(wr_valid_out),
    .out_ready_in(wr_ready_in),
    .out_data_out(fifo_out)
  );
  assign wr_addr_out = fifo_out[`FCHP_DATA_W+`FCHP_ADDR_W-1:`FCHP_DATA_W];
  assign wr_data_out = fifo_out[`FCHP_DATA_W-1:0];
endmodule
`default_nettype wire

// file: hdl/fchp_defines.svh
`ifndef FCHP_DEFINES_SVH
`define FCHP_DEFINES_SVH
`define FCHP_DATA_W 16
`define FCHP_BYTE_W 8
`define FCHP_ADDR_W 11
`define FCHP_TF_ADDR_W 3
`define FCHP_REGS 8
`define FCHP_FIFO_DEPTH 8
`define FCHP_INIT_NS 1000
`define FCHP_CLK_MHZ 200
`define FCHP_INIT_CYC ((`FCHP_INIT_NS * `FCHP_CLK_MHZ + 999) / 1000)
`define FCHP_STROBE_NS 40
`define FCHP_STROBE_CYC ((`FCHP_STROBE_NS * `FCHP_CLK_MHZ + 999) / 1000)
`define FCHP_LO_LANE 7:0
`define FCHP_HI_LANE 15:8
`endif

// file: hdl/fchp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module fchp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready_out = count != (AW+1)'(DEPTH);
  assign out_valid_out = count != '0;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: hdl/fchp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fchp_defines.svh"
module fchp_host
  import fchp_pkg::*;
#(
  parameter int STROBE_CYC = `FCHP_STROBE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ide_mode_in,
  input wire logic master_in,
  input wire logic card_reset_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire fchp_op_t req_op_in,
  input wire logic [`FCHP_ADDR_W-1:0] req_addr_in,
  input wire logic [`FCHP_DATA_W-1:0] req_data_in,
  output logic rsp_valid_out,
  output logic [`FCHP_DATA_W-1:0] rsp_data_out,
  fchp_bus_if.host bus
);
  typedef enum logic [2:0] {
    FCHP_IDLE = 3'b001,
    FCHP_STROBE = 3'b010,
    FCHP_RECOVER = 3'b100
  } fchp_hstate_t;
  fchp_hstate_t state;
  fchp_op_t op;
  logic [$clog2(STROBE_CYC+1)-1:0] cnt;
  logic [`FCHP_DATA_W-1:0] wdata;
  logic [`FCHP_ADDR_W-1:0] addr;

  assign bus.ide_mode_select_n = !ide_mode_in;
  assign bus.drive_role_select = !master_in;
  assign bus.reset_pin = card_reset_in;
  assign req_ready_out = state == FCHP_IDLE && bus.ready_busy_n;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= FCHP_IDLE;
      op <= FCHP_OP_READ;
      cnt <= '0;
      wdata <= 16'h0000;
      addr <= '0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
    end else begin
      rsp_valid_out <= 1'b0;
      unique case (state)
        FCHP_IDLE: begin
          if (req_valid_in && req_ready_out) begin
            state <= FCHP_STROBE;
            op <= req_op_in;
            wdata <= req_data_in;
            addr <= ide_mode_in ? {8'h00, req_addr_in[2:0]} : req_addr_in;
            cnt <= '0;
          end
        end
        FCHP_STROBE: begin
          if (cnt == ($bits(cnt))'(STROBE_CYC)) begin
            state <= FCHP_RECOVER;
            rsp_data_out <= bus.data;
            rsp_valid_out <= op != FCHP_OP_WRITE && op != FCHP_OP_CTLWR;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        FCHP_RECOVER: begin
          state <= FCHP_IDLE;
        end
        default: begin
          state <= FCHP_IDLE;
        end
      endcase
    end
  end

  assign bus.addr = state == FCHP_IDLE ? '0 : addr;
  assign bus.data_host = wdata;
  // in ide mode, control writes and task-file writes other than data word drive only low lane
  assign bus.data_host_oe = (state != FCHP_IDLE && (op == FCHP_OP_WRITE || op == FCHP_OP_CTLWR))
    ? ((ide_mode_in && (op == FCHP_OP_CTLWR || addr[2:0] != 3'h0)) ? 2'h1 : 2'h3) : 2'h0;
  assign bus.io_write_strobe_n = !(state == FCHP_STROBE &&
    (op == FCHP_OP_WRITE || op == FCHP_OP_CTLWR));
  assign bus.io_read_strobe_n = !(state == FCHP_STROBE &&
    (op == FCHP_OP_READ || op == FCHP_OP_CTLRD));
  assign bus.output_enable_n = !(state == FCHP_STROBE && op == FCHP_OP_MEMRD);
  assign bus.task_file_select_n = !(state != FCHP_IDLE &&
    (op == FCHP_OP_WRITE || op == FCHP_OP_READ));
  assign bus.control_block_select_n = !(state != FCHP_IDLE &&
    (op == FCHP_OP_CTLWR || op == FCHP_OP_CTLRD));
endmodule
`default_nettype wire

// file: hdl/fchp_pkg.sv
package fchp_pkg;
  typedef enum logic [1:0] {
    FCHP_MEM = 2'h0,
    FCHP_IO = 2'h1,
    FCHP_IDE = 2'h2
  } fchp_mode_t;
  typedef enum logic [2:0] {
    FCHP_OP_WRITE = 3'h0,
    FCHP_OP_READ = 3'h1,
    FCHP_OP_MEMRD = 3'h2,
    FCHP_OP_CTLWR = 3'h3,
    FCHP_OP_CTLRD = 3'h4
  } fchp_op_t;
endpackage
